/* mil_irq_logic.sv */
// Interrupt flags, enables, vectoring and wake control
`timescale 1ns/10ps
`default_nettype none
`include "mil_cfg.svh"
module mil_irq_logic #(
   parameter int PC_W = 13
) (
   input  wire logic          core_clk,
   input  wire logic          reset_n,
   input  wire logic          clk_en,
   input  wire mil_pkg::mil_bus_t bus,
   output logic [7:0]         rdata_ff,
   input  wire mil_pkg::mil_src_t src,
   input  wire logic          return_from_irq_instr,
   input  wire logic          sleep_instr,
   input  wire logic [PC_W-1:0] next_pc,
   output logic               irq_req_ff,
   output logic               vector_load_ff,
   output logic [PC_W-1:0]    vector_pc_ff,
   output logic               stack_push_ff,
   output logic [PC_W-1:0]    push_pc_ff,
   output logic               asleep_ff,
   output logic               wake_ff
);
   // ==============================================================
   // Elaboration check
   // Vector 0004h needs at least three counter bits
   if (PC_W < 3) begin : g_pc_width_check
      $error("PC_W too small for vector");
   end
   // ==============================================================
   // Registers and event detection
   logic [7:0] irq_control_reg;
   logic       global_en_ff;
   logic [3:0] irq_enables_ff;
   logic       ext_flag_ff;
   logic       timer_flag_ff;
   logic       port_flag_ff;
   logic       ctrl_write;
   logic       prime_ff;
   logic [7:0] option_ff;
   logic       ee_flag_ff;
   logic       ext_irq_pin_ff;
   logic [3:0] upper_io_port_ff;
   logic [1:0] lat_cnt_ff;
   mil_pkg::mil_state_t state_ff;
   logic       ext_edge;
   logic       port_chg;
   logic       pending;
   logic       wake_cond;
   logic       accept;
   logic       ext_edge_select;
   logic       global_irq_enable;
   localparam logic [7:0] CTRL_RST = `MIL_CTRL_RESET;

   assign ext_edge_select   = option_ff[`MIL_BIT_EDGE_SEL];
   assign global_irq_enable = global_en_ff;
   assign ctrl_write        = bus.wr && (bus.addr == `MIL_ADDR_CTRL);
   // Control register view, bit 7 down to bit 0
   assign irq_control_reg   = {global_en_ff, irq_enables_ff, timer_flag_ff, ext_flag_ff,
                               port_flag_ff};
   // No edge is taken from the first sample after reset: it has no history
   assign ext_edge = prime_ff & (ext_edge_select ? (src.ext_pin & ~ext_irq_pin_ff)
                                                 : (~src.ext_pin & ext_irq_pin_ff));
   assign port_chg = prime_ff & (|(src.upper_port ^ upper_io_port_ff));
   // A source wakes or requests only with its own enable set
   assign wake_cond =
        (ext_flag_ff   & irq_control_reg[`MIL_BIT_EXT_EN])
      | (timer_flag_ff & irq_control_reg[`MIL_BIT_TMR_EN])
      | (port_flag_ff  & irq_control_reg[`MIL_BIT_PORT_EN])
      | (ee_flag_ff    & irq_control_reg[`MIL_BIT_PERIPH_EN]);
   assign pending = wake_cond & global_irq_enable;
   assign accept  = (state_ff == mil_pkg::MIL_WAIT) && (lat_cnt_ff == 2'h0)
                    && pending;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         prime_ff         <= 1'b0;
         ext_irq_pin_ff   <= 1'b0;
         upper_io_port_ff <= 4'h0;
      end else if (clk_en) begin
         prime_ff         <= 1'b1;
         ext_irq_pin_ff   <= src.ext_pin;
         upper_io_port_ff <= src.upper_port;
      end
   end

   // ==============================================================
   // Control register: one process per field, hardware set wins over write
   // Global enable: accept beats return, return beats a plain write
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         global_en_ff <= CTRL_RST[`MIL_BIT_GLOBAL_EN];
      end else if (clk_en) begin
         if (accept) begin
            global_en_ff <= 1'b0;
         end else if (return_from_irq_instr) begin
            global_en_ff <= 1'b1;
         end else if (ctrl_write) begin
            global_en_ff <= bus.wdata[`MIL_BIT_GLOBAL_EN];
         end
      end
   end

   // Individual enables change only by software
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         irq_enables_ff <= CTRL_RST[`MIL_BIT_PERIPH_EN:`MIL_BIT_PORT_EN];
      end else if (clk_en && ctrl_write) begin
         irq_enables_ff <= bus.wdata[`MIL_BIT_PERIPH_EN:`MIL_BIT_PORT_EN];
      end
   end

   // Pin flag
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ext_flag_ff <= CTRL_RST[`MIL_BIT_EXT_FLAG];
      end else if (clk_en) begin
         if (ext_edge) begin
            ext_flag_ff <= 1'b1;
         end else if (ctrl_write) begin
            ext_flag_ff <= bus.wdata[`MIL_BIT_EXT_FLAG];
         end
      end
   end

   // Timer flag
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         timer_flag_ff <= CTRL_RST[`MIL_BIT_TMR_FLAG];
      end else if (clk_en) begin
         if (src.timer_wrap) begin
            timer_flag_ff <= 1'b1;
         end else if (ctrl_write) begin
            timer_flag_ff <= bus.wdata[`MIL_BIT_TMR_FLAG];
         end
      end
   end

   // Port change flag
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         port_flag_ff <= CTRL_RST[`MIL_BIT_PORT_FLAG];
      end else if (clk_en) begin
         if (port_chg) begin
            port_flag_ff <= 1'b1;
         end else if (ctrl_write) begin
            port_flag_ff <= bus.wdata[`MIL_BIT_PORT_FLAG];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         option_ff <= `MIL_OPTION_RESET;
      end else if (clk_en && bus.wr && bus.addr == `MIL_ADDR_OPTION) begin
         option_ff <= bus.wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ee_flag_ff <= 1'b0;
      end else if (clk_en) begin
         if (src.ee_done) begin
            ee_flag_ff <= 1'b1;
         end else if (bus.wr && bus.addr == `MIL_ADDR_EEFLAG) begin
            ee_flag_ff <= bus.wdata[0];
         end
      end
   end

   // ==============================================================
   // Read port
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rdata_ff <= 8'h00;
      end else if (clk_en) begin
         if (bus.rd) begin
            unique case (bus.addr)
               `MIL_ADDR_CTRL:   rdata_ff <= irq_control_reg;
               `MIL_ADDR_OPTION: rdata_ff <= option_ff;
               `MIL_ADDR_STATUS: rdata_ff <= {6'h00, asleep_ff, irq_req_ff};
               `MIL_ADDR_EEFLAG: rdata_ff <= {7'h00, ee_flag_ff};
               default:          rdata_ff <= 8'h00;
            endcase
         end else begin
            rdata_ff <= 8'h00;
         end
      end
   end

   // ==============================================================
   // Sequencer: latency count, sleep and vectoring
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_ff       <= mil_pkg::MIL_RUN;
         lat_cnt_ff     <= 2'h0;
         irq_req_ff     <= 1'b0;
         vector_load_ff <= 1'b0;
         vector_pc_ff   <= '0;
         stack_push_ff  <= 1'b0;
         push_pc_ff     <= '0;
         asleep_ff      <= 1'b0;
         wake_ff        <= 1'b0;
      end else if (clk_en) begin
         vector_load_ff <= 1'b0;
         stack_push_ff  <= 1'b0;
         wake_ff        <= 1'b0;
         irq_req_ff     <= pending;
         unique case (state_ff)
            mil_pkg::MIL_RUN: begin
               if (sleep_instr && !wake_cond) begin
                  state_ff  <= mil_pkg::MIL_SLEEP;
                  asleep_ff <= 1'b1;
               end else if (pending) begin
                  state_ff   <= mil_pkg::MIL_WAIT;
                  lat_cnt_ff <= `MIL_LAT_CYCLES - 2'h1;
               end
            end
            mil_pkg::MIL_WAIT: begin
               if (!pending) begin
                  state_ff <= mil_pkg::MIL_RUN;
               end else if (lat_cnt_ff != 2'h0) begin
                  lat_cnt_ff <= lat_cnt_ff - 2'h1;
               end else begin
                  state_ff       <= mil_pkg::MIL_RUN;
                  stack_push_ff  <= 1'b1;
                  push_pc_ff     <= next_pc;
                  vector_load_ff <= 1'b1;
                  vector_pc_ff   <= PC_W'(`MIL_VECTOR);
               end
            end
            mil_pkg::MIL_SLEEP: begin
               if (wake_cond) begin
                  state_ff  <= mil_pkg::MIL_RUN;
                  asleep_ff <= 1'b0;
                  wake_ff   <= 1'b1;
               end
            end
         endcase
      end
   end

   // ==============================================================
   // Checks
   default clocking cb_chk @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   a_vector_after_accept: assert property (
      clk_en && accept |=> vector_load_ff && stack_push_ff)
      else $error("vector not loaded after accept");
   a_global_clears: assert property (
      clk_en && accept |=> !global_en_ff)
      else $error("global enable not cleared");
   a_return_sets: assert property (
      clk_en && return_from_irq_instr && !accept |=> global_en_ff)
      else $error("return did not set global enable");
   a_no_accept_off: assert property (
      !global_irq_enable |-> !accept)
      else $error("accept with global clear");
   a_flag_on_edge: assert property (
      clk_en && ext_edge |=> ext_flag_ff)
      else $error("pin flag not set");
   a_timer_flag: assert property (
      clk_en && src.timer_wrap |=> timer_flag_ff)
      else $error("timer flag not set");
   a_port_flag: assert property (
      clk_en && port_chg |=> port_flag_ff)
      else $error("port flag not set");
   a_wake_sleep: assert property (
      clk_en && state_ff == mil_pkg::MIL_SLEEP && wake_cond |=> wake_ff && !asleep_ff)
      else $error("no wake from sleep");
   a_vector_value: assert property (
      vector_load_ff |-> vector_pc_ff == PC_W'(`MIL_VECTOR))
      else $error("wrong vector");
   // Reset itself must clear the global enable, so this one is never disabled
   a_reset_clears: assert property (
      disable iff (1'b0) !reset_n |=> !global_en_ff)
      else $error("reset left global enable set");
   a_req_follows: assert property (
      clk_en |=> irq_req_ff == $past(pending))
      else $error("request does not follow pending");
   a_req_needs_global: assert property (
      clk_en && !global_irq_enable |=> !irq_req_ff)
      else $error("request with global clear");
   a_masked_quiet: assert property (
      clk_en && irq_enables_ff == 4'h0 |=> !irq_req_ff)
      else $error("request with all sources masked");
   a_sleep_nop: assert property (
      clk_en && state_ff == mil_pkg::MIL_RUN && sleep_instr && wake_cond |=> !asleep_ff)
      else $error("sleep taken with source pending");
   a_sleep_entry: assert property (
      clk_en && state_ff == mil_pkg::MIL_RUN && sleep_instr && !wake_cond |=> asleep_ff)
      else $error("sleep not entered");
   a_stay_asleep: assert property (
      clk_en && state_ff == mil_pkg::MIL_SLEEP && !wake_cond |=> asleep_ff)
      else $error("woke without enabled source");
   a_push_return: assert property (
      clk_en && accept |=> push_pc_ff == $past(next_pc))
      else $error("wrong return address pushed");
   a_wait_entry: assert property (
      clk_en && state_ff == mil_pkg::MIL_RUN && pending |=> state_ff == mil_pkg::MIL_WAIT)
      else $error("latency count not started");
   a_vector_pulse: assert property (
      clk_en && vector_load_ff |=> !vector_load_ff)
      else $error("vector load longer than one cycle");
   a_nest_blocked: assert property (
      vector_load_ff |-> !global_irq_enable)
      else $error("global enable set during vectoring");
   a_ee_flag: assert property (
      clk_en && src.ee_done |=> ee_flag_ff)
      else $error("write complete flag not set");
   a_freeze_holds: assert property (
      !clk_en |=> $stable(irq_control_reg) && $stable(state_ff))
      else $error("state moved while frozen");
   a_rdata_idle: assert property (
      clk_en && !bus.rd |=> rdata_ff == 8'h00)
      else $error("read data without read");
   c_accept: cover property (accept);
   c_wake: cover property (wake_ff);
   c_return: cover property (return_from_irq_instr);
   c_asleep: cover property (asleep_ff);
   c_ee_flag: cover property (ee_flag_ff && global_irq_enable);
endmodule : mil_irq_logic
`default_nettype wire

/* mil_cfg.svh */
// Constants for the interrupt logic block
`ifndef MIL_CFG_SVH
`define MIL_CFG_SVH
`define MIL_ADDR_CTRL      4'h0
`define MIL_ADDR_OPTION    4'h1
`define MIL_ADDR_STATUS    4'h2
`define MIL_ADDR_EEFLAG    4'h3
`define MIL_BIT_PORT_FLAG  0
`define MIL_BIT_EXT_FLAG   1
`define MIL_BIT_TMR_FLAG   2
`define MIL_BIT_PORT_EN    3
`define MIL_BIT_EXT_EN     4
`define MIL_BIT_TMR_EN     5
`define MIL_BIT_PERIPH_EN  6
`define MIL_BIT_GLOBAL_EN  7
`define MIL_BIT_EDGE_SEL   6
`define MIL_CTRL_RESET     8'h00
`define MIL_OPTION_RESET   8'hFF
`define MIL_VECTOR         13'h0004
`define MIL_LAT_CYCLES     2'h3
`endif

/* mil_pkg.sv */
// Types for the interrupt logic block
package mil_pkg;
   typedef struct packed {
      logic       ext_pin;
      logic       timer_wrap;
      logic [3:0] upper_port;
      logic       ee_done;
   } mil_src_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } mil_bus_t;
   typedef enum logic [2:0] {
      MIL_RUN   = 3'b001,
      MIL_WAIT  = 3'b010,
      MIL_SLEEP = 3'b100
   } mil_state_t;
endpackage : mil_pkg

/* mil_core_model.sv */
// Behavioural processor core facing the interrupt logic
`timescale 1ns/10ps
`default_nettype none
module mil_core_model (
   input  wire logic        core_clk,
   input  wire logic        vec_load,
   input  wire logic [12:0] vec_pc,
   input  wire logic        ret_go,
   output var  logic [12:0] next_pc,
   output var  logic        ret_pulse
);
   initial begin
      next_pc   = 13'h0100;
      ret_pulse = 1'b0;
   end
   // Jump to the vector, continue from the word after it
   always @(posedge core_clk) begin
      if (vec_load) next_pc <= vec_pc + 13'h0001;
      ret_pulse <= ret_go;
   end
endmodule : mil_core_model
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the interrupt logic block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic              core_clk;
   logic              clk_en;
   logic              reset_n;
   mil_pkg::mil_bus_t bus;
   mil_pkg::mil_src_t src;
   logic [7:0]        rdata;
   logic              ret, ret_go, slp, irq, vld, push, aslp, wake;
   logic [12:0]       npc, vpc, ppc;
   logic [7:0]        r;
   int                failures, check_count;
   mil_irq_logic uut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .bus(bus),
      .rdata_ff(rdata), .src(src), .return_from_irq_instr(ret), .sleep_instr(slp),
      .next_pc(npc), .irq_req_ff(irq), .vector_load_ff(vld), .vector_pc_ff(vpc),
      .stack_push_ff(push), .push_pc_ff(ppc), .asleep_ff(aslp), .wake_ff(wake));
   mil_core_model core (.core_clk(core_clk), .vec_load(vld), .vec_pc(vpc),
      .ret_go(ret_go), .next_pc(npc), .ret_pulse(ret));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task summarize;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task chk(input string n, input logic [12:0] e, input logic [12:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk) bus.wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk) bus.rd <= 1'b0;
      #1 r = rdata;
   endtask : rd
   // Bounded wait for the vector load (s=0) or the wake pulse (s=1)
   task wt(input int s, output int n);
      n = 0;
      while (((s == 1) ? wake : vld) !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n == 20) begin
         failures++;
         summarize();
      end
   endtask : wt
   task t_reset;
      rd(4'h0); chk("ctrl_rst", 8'h00, r);
      rd(4'h1); chk("opt_rst", 8'hFF, r);
      rd(4'h7); chk("unmapped", 8'h00, r);
      $display("t_reset done");
   endtask : t_reset
   task t_timer;
      int n;
      @(posedge core_clk) src.timer_wrap <= 1'b1;
      @(posedge core_clk) src.timer_wrap <= 1'b0;
      rd(4'h0); chk("tmr_flag", 8'h04, r);
      chk("irq_off", 1'b0, irq);
      wr(4'h0, 8'hA4);
      wt(0, n); chk("vec_pc", 13'h0004, vpc);
      chk("push", 1'b1, push);
      chk("push_pc", 13'h0100, ppc);
      rd(4'h0); chk("gie_clr", 8'h24, r);
      chk("no_nest", 1'b0, irq);
      wr(4'h0, 8'h20);
      @(posedge core_clk) ret_go <= 1'b1;
      @(posedge core_clk) ret_go <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(4'h0); chk("gie_set", 8'hA0, r);
      wr(4'h0, 8'h00);
      $display("t_timer done");
   endtask : t_timer
   task t_ext;
      wr(4'h1, 8'hBF);
      wr(4'h0, 8'h80);
      @(posedge core_clk) src.ext_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(4'h0); chk("rise_ign", 8'h80, r);
      @(posedge core_clk) src.ext_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(4'h0); chk("fall_flag", 8'h82, r);
      chk("ext_masked", 1'b0, irq);
      wr(4'h0, 8'h00);
      $display("t_ext done");
   endtask : t_ext
   task t_port;
      int n;
      wr(4'h0, 8'h88);
      @(posedge core_clk) src.upper_port <= 4'h5;
      wt(0, n); chk("port_lat", 1'b1, n >= 3 && n <= 5);
      rd(4'h0); chk("port_flag", 8'h09, r);
      wr(4'h0, 8'h00);
      $display("t_port done");
   endtask : t_port
   task t_sleep;
      int n;
      wr(4'h1, 8'hFF);
      wr(4'h0, 8'h10);
      @(posedge core_clk) slp <= 1'b1;
      @(posedge core_clk) slp <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("asleep", 1'b1, aslp);
      @(posedge core_clk) src.ext_pin <= 1'b1;
      wt(1, n); chk("woke", 1'b1, wake);
      repeat (6) @(posedge core_clk);
      chk("no_vec", 1'b0, vld);
      rd(4'h0); chk("wake_flag", 8'h12, r);
      $display("t_sleep done");
   endtask : t_sleep
   task t_wake_vec;
      int n;
      @(posedge core_clk) src.ext_pin <= 1'b0;
      wr(4'h0, 8'h90);
      @(posedge core_clk) slp <= 1'b1;
      @(posedge core_clk) slp <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("asleep2", 1'b1, aslp);
      @(posedge core_clk) src.ext_pin <= 1'b1;
      wt(1, n); chk("woke2", 1'b1, wake);
      wt(0, n); chk("wake_vec", 13'h0004, vpc);
      wr(4'h0, 8'h00);
      $display("t_wake_vec done");
   endtask : t_wake_vec
   task t_ee;
      int n;
      wr(4'h0, 8'hC0);
      @(posedge core_clk) src.ee_done <= 1'b1;
      @(posedge core_clk) src.ee_done <= 1'b0;
      rd(4'h2); chk("status_req", 8'h01, r);
      rd(4'h3); chk("ee_flag", 8'h01, r);
      wt(0, n); chk("ee_vec", 13'h0004, vpc);
      wr(4'h3, 8'h00);
      rd(4'h3); chk("ee_clr", 8'h00, r);
      wr(4'h0, 8'h00);
      $display("t_ee done");
   endtask : t_ee
   task t_freeze;
      @(posedge core_clk) clk_en <= 1'b0;
      @(posedge core_clk) src.timer_wrap <= 1'b1;
      @(posedge core_clk) src.timer_wrap <= 1'b0;
      @(posedge core_clk) clk_en <= 1'b1;
      rd(4'h0); chk("frozen", 8'h00, r);
      $display("t_freeze done");
   endtask : t_freeze
   task t_rst_mid;
      wr(4'h0, 8'hA8);
      @(posedge core_clk) reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(4'h0); chk("ctrl_mid_rst", 8'h00, r);
      rd(4'h1); chk("opt_mid_rst", 8'hFF, r);
      $display("t_rst_mid done");
   endtask : t_rst_mid
   initial begin
      bus = '0;
      src = '0;
      slp = 1'b0;
      clk_en = 1'b1;
      ret_go = 1'b0;
      reset_n = 1'b0;
      failures = 0;
      check_count = 0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      t_reset;
      t_timer;
      t_ext;
      t_port;
      t_sleep;
      t_wake_vec;
      t_ee;
      t_freeze;
      t_rst_mid;
      summarize;
   end
endmodule : tb_top
`default_nettype wire
